// ### core/tsq_cfg.svh
// tsq_cfg.svh: register offsets, field positions, reset values and encodings of the trigger qualifier
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef TSQ_CFG_SVH
`define TSQ_CFG_SVH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define TSQ_OFS_CTRL    8'h00
`define TSQ_OFS_WIDTH   8'h04
`define TSQ_OFS_DELTA   8'h08
`define TSQ_OFS_DELAY   8'h0C
`define TSQ_OFS_COUNT   8'h10
`define TSQ_OFS_TMO     8'h14
`define TSQ_OFS_STAT    8'h18
`define TSQ_OFS_IRQST   8'h1C
`define TSQ_OFS_IRQMSK  8'h20
`define TSQ_OFS_EVCNT   8'h24

// ***************************************************************
// control register fields
// ***************************************************************
`define TSQ_C_ARM       0
`define TSQ_C_SEQ       1
`define TSQ_C_RSTEV     2
`define TSQ_C_RSTTM     3
`define TSQ_C_EXT       4
`define TSQ_C_NREJ      5
`define TSQ_C_TYPE_LO   6
`define TSQ_C_TYPE_HI   7
`define TSQ_C_SLOPE_LO  8
`define TSQ_C_SLOPE_HI  9
`define TSQ_C_RANGE_LO  10
`define TSQ_C_RANGE_HI  12
`define TSQ_C_SRC_LO    16
`define TSQ_C_SRC_HI    17
`define TSQ_C_ASRC_LO   18
`define TSQ_C_ASRC_HI   19
`define TSQ_C_RSRC_LO   20
`define TSQ_C_RSRC_HI   21
`define TSQ_CTRL_RST    32'h0000_0000

// ***************************************************************
// encodings
// ***************************************************************
`define TSQ_TY_EDGE     2'h0
`define TSQ_TY_GLITCH   2'h1
`define TSQ_TY_WIDTH    2'h2
`define TSQ_TY_RUNT     2'h3
`define TSQ_SL_POS      2'h0
`define TSQ_SL_NEG      2'h1
`define TSQ_SL_EITHER   2'h2
`define TSQ_RG_LONGER   3'h0
`define TSQ_RG_SHORTER  3'h1
`define TSQ_RG_WITHIN   3'h2
`define TSQ_RG_OUTSIDE  3'h3
`define TSQ_RG_ANY      3'h4

// interrupt status bits
`define TSQ_IRQ_TRIG    0
`define TSQ_IRQ_RESET   1
`define TSQ_IRQ_WIDTH   2

`endif

// ### core/tsq_pkg.sv
// tsq_pkg.sv: types shared by the trigger qualifier
// assumes tsq_cfg.svh for numeric values
package tsq_pkg;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    TSQ_IDLE  = 4'b0001,
    TSQ_WAITA = 4'b0010,
    TSQ_DELAY = 4'b0100,
    TSQ_CNTB  = 4'b1000
  } tsq_seq_type;
endpackage

// ### core/tsq_top.sv
// tsq_top.sv: trigger sequencer with edge, glitch, width and runt qualifiers behind wishbone
// assumes comparator bits come from the sample-clock domain already; ext bit is an async pin
`include "tsq_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module tsq_top
  import tsq_pkg::*;
#(
  parameter int NCH = 4,
  parameter int TW  = 24
) (
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic           ce_i,
  input  wire logic [NCH-1:0] lvl_hi_i,
  input  wire logic [NCH-1:0] lvl_lo_i,
  input  wire logic           ext_i,
  input  wire logic           ext_hyst_i,
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [7:0]     wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic      [31:0]    wb_dat_o,
  output logic                wb_ack_o,
  output logic                trig_o,
  output logic                irq_o
);

  // ***************************************************************
  // registers and declarations
  // ***************************************************************
  logic [31:0]   ctrl_ff;
  logic [TW-1:0] width_ff, delta_ff, delay_ff, tmo_ff;
  logic [15:0]   count_ff;
  logic [2:0]    irqst_ff, irqmsk_ff;
  logic [15:0]   evcnt_ff;
  logic [31:0]   rdat_ff;
  logic          ack_ff;
  logic          ext_s1_ff, ext_s2_ff, exth_s1_ff, exth_s2_ff, ext_st_ff;
  logic [NCH-1:0] hi_d_ff, lo_d_ff;
  logic          ext_d_ff;
  tsq_seq_type   seq_ff, nxt_seq;
  logic [TW-1:0] tim_ff, nxt_tim;
  logic [15:0]   bcnt_ff, nxt_bcnt;
  logic [TW-1:0] pw_ff [3];        // per-event pulse timer (a, b, r)
  logic [2:0]    pact_ff, ppol_ff;
  logic [2:0]    rarm_ff;          // runt: crossed first, awaiting return
  logic          trig_ff;

  // ***************************************************************
  // field decode
  // ***************************************************************
  wire       armed    = ctrl_ff[`TSQ_C_ARM];
  wire       seq_mode = ctrl_ff[`TSQ_C_SEQ];
  wire       rst_ev   = ctrl_ff[`TSQ_C_RSTEV];
  wire       rst_tm   = ctrl_ff[`TSQ_C_RSTTM];
  wire       use_ext  = ctrl_ff[`TSQ_C_EXT] & ~seq_mode;
  wire       nrej     = ctrl_ff[`TSQ_C_NREJ];
  wire [1:0] ttype    = ctrl_ff[`TSQ_C_TYPE_HI:`TSQ_C_TYPE_LO];
  wire [1:0] slope    = ctrl_ff[`TSQ_C_SLOPE_HI:`TSQ_C_SLOPE_LO];
  wire [2:0] rng      = ctrl_ff[`TSQ_C_RANGE_HI:`TSQ_C_RANGE_LO];
  wire [1:0] src_b    = ctrl_ff[`TSQ_C_SRC_HI:`TSQ_C_SRC_LO];
  wire [1:0] src_a    = ctrl_ff[`TSQ_C_ASRC_HI:`TSQ_C_ASRC_LO];
  wire [1:0] src_r    = ctrl_ff[`TSQ_C_RSRC_HI:`TSQ_C_RSRC_LO];
  // external type is forced to edge since no pulse qualifier is offered there
  wire [1:0] etype    = use_ext ? `TSQ_TY_EDGE : ttype;

  // ***************************************************************
  // external pin synchroniser with noise reject
  // ***************************************************************
  // the hysteresis comparator output only moves the state when it agrees
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1_ff  <= 1'b0;
      ext_s2_ff  <= 1'b0;
      exth_s1_ff <= 1'b0;
      exth_s2_ff <= 1'b0;
      ext_st_ff  <= 1'b0;
    end else if (ce_i) begin
      ext_s1_ff  <= ext_i;
      ext_s2_ff  <= ext_s1_ff;
      exth_s1_ff <= ext_hyst_i;
      exth_s2_ff <= exth_s1_ff;
      ext_st_ff  <= nrej ? ((ext_s2_ff & exth_s2_ff) | (ext_st_ff & (ext_s2_ff | exth_s2_ff)))
                         : ext_s2_ff;
    end
  end

  // ***************************************************************
  // comparator history, crossings per sample
  // ***************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_d_ff  <= '0;
      lo_d_ff  <= '0;
      ext_d_ff <= 1'b0;
    end else if (ce_i) begin
      hi_d_ff  <= lvl_hi_i;
      lo_d_ff  <= lvl_lo_i;
      ext_d_ff <= ext_st_ff;
    end
  end

  wire [NCH-1:0] lo_rise = lvl_lo_i & ~lo_d_ff;
  wire [NCH-1:0] lo_fall = ~lvl_lo_i & lo_d_ff;
  wire [NCH-1:0] hi_rise = lvl_hi_i & ~hi_d_ff;
  wire [NCH-1:0] hi_fall = ~lvl_hi_i & hi_d_ff;
  wire           ex_rise = ext_st_ff & ~ext_d_ff;
  wire           ex_fall = ~ext_st_ff & ext_d_ff;

  // slope match; either accepts a rising or a falling crossing
  function automatic logic slope_hit(input logic [1:0] s, input logic r, input logic f);
    case (s)
      `TSQ_SL_POS:    slope_hit = r;
      `TSQ_SL_NEG:    slope_hit = f;
      `TSQ_SL_EITHER: slope_hit = r | f;
      default:        slope_hit = 1'b0;
    endcase
  endfunction

  // range check on a measured pulse length
  function automatic logic range_hit(input logic [2:0] rg, input logic [TW-1:0] len,
                                     input logic [TW-1:0] w, input logic [TW-1:0] d);
    logic [TW:0] lo_b;
    logic [TW:0] hi_b;
    lo_b = ({1'b0, w} > {1'b0, d}) ? ({1'b0, w} - {1'b0, d}) : '0;
    hi_b = {1'b0, w} + {1'b0, d};
    case (rg)
      `TSQ_RG_LONGER:  range_hit = len > w;
      `TSQ_RG_SHORTER: range_hit = len < w;
      `TSQ_RG_WITHIN:  range_hit = ({1'b0, len} >= lo_b) && ({1'b0, len} <= hi_b);
      `TSQ_RG_OUTSIDE: range_hit = ({1'b0, len} < lo_b) || ({1'b0, len} > hi_b);
      `TSQ_RG_ANY:     range_hit = 1'b1;
      default:         range_hit = 1'b0;
    endcase
  endfunction

  // ***************************************************************
  // three event qualifiers (A, B, R) on selectable channels
  // ***************************************************************
  logic [2:0] ev_hit;
  wire  [1:0] ev_src [3];
  assign ev_src[0] = src_a;
  assign ev_src[1] = src_b;
  assign ev_src[2] = src_r;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ev
      // B is the single-event qualifier, so only it may take the external input
      wire ext_sel = (g == 1) && use_ext;
      wire r_c  = ext_sel ? ex_rise : lo_rise[ev_src[g]];
      wire f_c  = ext_sel ? ex_fall : lo_fall[ev_src[g]];
      wire hr_c = hi_rise[ev_src[g]];
      wire hf_c = hi_fall[ev_src[g]];
      // pulse start: rising for positive, falling for negative
      wire p_st = armed & ~pact_ff[g] & slope_hit(slope, r_c, f_c);
      wire p_nd = pact_ff[g] & (ppol_ff[g] ? f_c : r_c);
      wire [TW-1:0] len = pw_ff[g];
      wire edge_h  = slope_hit(slope, r_c, f_c);
      wire glit_h  = p_nd & range_hit(rng[0] ? `TSQ_RG_SHORTER : `TSQ_RG_LONGER,
                                      len, width_ff, delta_ff);
      wire wid_h   = p_nd & range_hit(rng, len, width_ff, delta_ff);
      // runt: first level crossed back before the second was crossed
      wire runt_h  = rarm_ff[g] & (ppol_ff[g] ? f_c : r_c);

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pw_ff[g]   <= '0;
          pact_ff[g] <= 1'b0;
          ppol_ff[g] <= 1'b0;
          rarm_ff[g] <= 1'b0;
        end else if (ce_i) begin
          if (p_st) begin
            pact_ff[g] <= 1'b1;
            ppol_ff[g] <= r_c;
            rarm_ff[g] <= 1'b1;
            pw_ff[g]   <= {{(TW-1){1'b0}}, 1'b1};
          end else if (p_nd || !armed) begin
            // disarming drops a half-seen pulse so a stale slope cannot end it later
            pact_ff[g] <= 1'b0;
            rarm_ff[g] <= 1'b0;
          end else if (pact_ff[g]) begin
            if (~&pw_ff[g])
              pw_ff[g] <= pw_ff[g] + {{(TW-1){1'b0}}, 1'b1};
            if (ppol_ff[g] ? hr_c : hf_c)
              rarm_ff[g] <= 1'b0;   // second level reached: not a runt
          end
        end
      end

      always_comb begin
        case (etype)
          `TSQ_TY_EDGE:   ev_hit[g] = edge_h;
          `TSQ_TY_GLITCH: ev_hit[g] = glit_h;
          `TSQ_TY_WIDTH:  ev_hit[g] = wid_h;
          `TSQ_TY_RUNT:   ev_hit[g] = runt_h;
          default:        ev_hit[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // ***************************************************************
  // sequencer
  // ***************************************************************
  wire tmo_done = rst_tm && (tim_ff >= tmo_ff);
  logic fire;
  logic seq_reset;

  always_comb begin
    nxt_seq   = seq_ff;
    nxt_tim   = tim_ff;
    nxt_bcnt  = bcnt_ff;
    fire      = 1'b0;
    seq_reset = 1'b0;
    case (seq_ff)
      TSQ_IDLE: begin
        if (armed)
          nxt_seq = seq_mode ? TSQ_WAITA : TSQ_CNTB;
        nxt_tim  = '0;
        nxt_bcnt = '0;
      end
      TSQ_WAITA: begin
        nxt_tim  = '0;
        nxt_bcnt = '0;
        if (ev_hit[0])
          nxt_seq = TSQ_DELAY;
      end
      TSQ_DELAY: begin
        // B hits are dropped here
        nxt_tim = tim_ff + {{(TW-1){1'b0}}, 1'b1};
        if (tim_ff + {{(TW-1){1'b0}}, 1'b1} >= delay_ff) begin
          nxt_seq = TSQ_CNTB;
          nxt_tim = '0;
        end
      end
      TSQ_CNTB: begin
        nxt_tim = tim_ff + {{(TW-1){1'b0}}, 1'b1};
        if (!seq_mode) begin
          fire = ev_hit[1];   // single event
        end else if (rst_ev && ev_hit[2]) begin
          nxt_seq   = TSQ_WAITA;
          seq_reset = 1'b1;
        end else if (ev_hit[1] && (bcnt_ff + 16'h0001 >= count_ff)) begin
          fire    = 1'b1;
          nxt_seq = TSQ_WAITA;
        end else if (tmo_done) begin
          nxt_seq   = TSQ_WAITA;
          seq_reset = 1'b1;
        end else if (ev_hit[1]) begin
          nxt_bcnt = bcnt_ff + 16'h0001;
        end
      end
      default: nxt_seq = TSQ_IDLE;
    endcase
    if (!armed)
      nxt_seq = TSQ_IDLE;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_ff  <= TSQ_IDLE;
      tim_ff  <= '0;
      bcnt_ff <= '0;
      trig_ff <= 1'b0;
    end else if (ce_i) begin
      seq_ff  <= nxt_seq;
      tim_ff  <= nxt_tim;
      bcnt_ff <= nxt_bcnt;
      trig_ff <= fire;
    end
  end

  // ***************************************************************
  // wishbone slave, one wait state, ack after each request
  // ***************************************************************
  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wb_wr  = wb_req & wb_we_i;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  wire [31:0] w_ctrl  = merge(ctrl_ff, wb_dat_i, wmask);
  wire [31:0] w_width = merge({{(32-TW){1'b0}}, width_ff}, wb_dat_i, wmask);
  wire [31:0] w_delta = merge({{(32-TW){1'b0}}, delta_ff}, wb_dat_i, wmask);
  wire [31:0] w_delay = merge({{(32-TW){1'b0}}, delay_ff}, wb_dat_i, wmask);
  wire [31:0] w_tmo   = merge({{(32-TW){1'b0}}, tmo_ff}, wb_dat_i, wmask);
  wire [31:0] w_count = merge({16'h0000, count_ff}, wb_dat_i, wmask);
  wire [31:0] w_imsk  = merge({29'h0, irqmsk_ff}, wb_dat_i, wmask);
  wire [2:0]  w1c     = (wb_wr && wb_adr_i == `TSQ_OFS_IRQST) ? (wb_dat_i[2:0] & wmask[2:0]) : 3'h0;
  wire [2:0]  irq_ev  = {ev_hit[1] & (etype == `TSQ_TY_WIDTH), seq_reset, fire};

  // read mux; unmapped offsets read zero
  logic [31:0] rmux;
  always_comb begin
    case (wb_adr_i)
      `TSQ_OFS_CTRL:   rmux = ctrl_ff;
      `TSQ_OFS_WIDTH:  rmux = {{(32-TW){1'b0}}, width_ff};
      `TSQ_OFS_DELTA:  rmux = {{(32-TW){1'b0}}, delta_ff};
      `TSQ_OFS_DELAY:  rmux = {{(32-TW){1'b0}}, delay_ff};
      `TSQ_OFS_COUNT:  rmux = {16'h0000, count_ff};
      `TSQ_OFS_TMO:    rmux = {{(32-TW){1'b0}}, tmo_ff};
      `TSQ_OFS_STAT:   rmux = {12'h000, bcnt_ff, seq_ff};
      `TSQ_OFS_IRQST:  rmux = {29'h0, irqst_ff};
      `TSQ_OFS_IRQMSK: rmux = {29'h0, irqmsk_ff};
      `TSQ_OFS_EVCNT:  rmux = {16'h0000, evcnt_ff};
      default:         rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff   <= `TSQ_CTRL_RST;
      width_ff  <= '0;
      delta_ff  <= '0;
      delay_ff  <= '0;
      tmo_ff    <= '0;
      count_ff  <= 16'h0001;
      irqmsk_ff <= 3'h0;
      ack_ff    <= 1'b0;
      rdat_ff   <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_ff  <= wb_req;
      rdat_ff <= wb_req ? rmux : 32'h0000_0000;
      if (wb_wr) begin
        case (wb_adr_i)
          `TSQ_OFS_CTRL:   ctrl_ff   <= w_ctrl;
          `TSQ_OFS_WIDTH:  width_ff  <= w_width[TW-1:0];
          `TSQ_OFS_DELTA:  delta_ff  <= w_delta[TW-1:0];
          `TSQ_OFS_DELAY:  delay_ff  <= w_delay[TW-1:0];
          `TSQ_OFS_COUNT:  count_ff  <= w_count[15:0];
          `TSQ_OFS_TMO:    tmo_ff    <= w_tmo[TW-1:0];
          `TSQ_OFS_IRQMSK: irqmsk_ff <= w_imsk[2:0];
          default: ;
        endcase
      end
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irqst_ff <= 3'h0;
      evcnt_ff <= 16'h0000;
    end else if (ce_i) begin
      irqst_ff <= (irqst_ff & ~w1c) | irq_ev;
      if (fire)
        evcnt_ff <= evcnt_ff + 16'h0001;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign trig_o   = trig_ff;
  assign irq_o    = |(irqst_ff & irqmsk_ff);

endmodule
`default_nettype wire

// ### bench/tsq_chk.sv
// tsq_chk.sv: port-level timing checks of the trigger qualifier, bound into tsq_top
// assumes one clock clk_i and a synchronous active-high rst_i
`timescale 1ns/100ps
`default_nettype none
module tsq_chk #(
  parameter int NCH = 4,
  parameter int TW  = 24
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        trig_o,
  input wire logic        irq_o
);
  // ***************************************************************
  // bus, trigger and interrupt relations
  // ***************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_once_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i && ce_i))
    else $error("ack without request");
  ack_held_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack outside a held request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero without ack");
  rst_quiet_a: assert property ($past(rst_i) |-> !wb_ack_o && !trig_o && !irq_o)
    else $error("outputs active after reset");
  freeze_a: assert property (!ce_i |=> $stable(trig_o) && $stable(wb_ack_o))
    else $error("state moved while clock enable low");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_we_i && wb_stb_i)
    || $past(wb_we_i && wb_stb_i, 2))
    else $error("interrupt dropped without a write");
  cover property (trig_o);
  cover property ($rose(irq_o));
  cover property (wb_ack_o && wb_we_i);
endmodule
bind tsq_top tsq_chk #(.NCH(NCH), .TW(TW)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .trig_o(trig_o), .irq_o(irq_o));
`default_nettype wire

// ### bench/tb.sv
// tb.sv: self-checking bench of the trigger qualifier, random pulses with corner cases
// assumes tsq_top on one 10 MHz clock and the wishbone map of tsq_cfg.svh
`include "tsq_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tsq_pkg::*;
  logic        clk_i, rst_i, ce_i, ext_i, ext_hyst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0]  lvl_hi_i, lvl_lo_i, wb_sel_i;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        wb_ack_o, trig_o, irq_o;
  int          n_mismatch, checks_done, n_trig, n_all, cyc_cnt, seed, c, w, l, dl, ty, rg, p;
  logic [7:0]  ra [6] = '{`TSQ_OFS_CTRL, `TSQ_OFS_COUNT, `TSQ_OFS_IRQST, `TSQ_OFS_IRQMSK,
                          `TSQ_OFS_EVCNT, 8'h3C};
  logic [31:0] rv [6] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
  tsq_top #(.NCH(4), .TW(24)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .lvl_hi_i(lvl_hi_i), .lvl_lo_i(lvl_lo_i), .ext_i(ext_i), .ext_hyst_i(ext_hyst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .trig_o(trig_o), .irq_o(irq_o));
  // ***************************************************************
  // clock, trigger counting and watchdog
  // ***************************************************************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // the ceiling is far above the fewer than 1500 cycles the tests need
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (trig_o === 1'b1) begin
      n_trig++;
      n_all++;
    end
    if (cyc_cnt == 30000) begin
      n_mismatch++;
      results;
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; no fixed latency assumed, the watchdog ends a hang
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // a pulse of len samples on the trigger-level bit, away from its idle level and back
  task automatic pls(input int ch, input int len);
    lvl_lo_i[ch] <= ~lvl_lo_i[ch];
    repeat (len) @(posedge clk_i);
    lvl_lo_i[ch] <= ~lvl_lo_i[ch];
    repeat (4) @(posedge clk_i);
  endtask
  function automatic logic [31:0] cfg(input int t, input int s, input int r, input int ch);
    return 32'h1 | 32'(t << 6) | 32'(s << 8) | 32'(r << 10) | 32'(ch << 16);
  endfunction
  // expected hit of the glitch (type 1) and width qualifiers for one pulse length
  function automatic int hit(input int t, input int r, input int len, input int wd, input int d);
    if (t == 1) return (r == 1) ? len < wd : len > wd;
    case (r)
      0: return len > wd;
      1: return len < wd;
      2: return len >= wd - d && len <= wd + d;
      default: return len < wd - d || len > wd + d;
    endcase
  endfunction
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    seed = 4604;
    {rst_i, ce_i, ext_i, ext_hyst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 7'b1100000;
    {lvl_hi_i, lvl_lo_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ra[i]) begin
      wb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    ce_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    ce_i <= 1'b1;
    // edge mode per slope; a pulse on a neighbour channel must not count
    for (int s = 0; s < 3; s++) begin
      c = $unsigned($random(seed)) % 4;
      wb(1'b1, `TSQ_OFS_CTRL, cfg(0, s, 0, c));
      n_trig = 0;
      pls((c + 1) % 4, 3);
      pls(c, 3);
      chk(n_trig, (s == 2) ? 2 : 1);
    end
    // glitch and width: first 16 runs hold zero tolerance and lengths at and next to width
    for (int i = 0; i < 40; i++) begin
      ty = 1 + i % 2;
      rg = (i / 2) % 4;
      p = (i / 3) % 3;
      c = $unsigned($random(seed)) % 4;
      w = 3 + $unsigned($random(seed)) % 6;
      dl = (i < 16) ? 0 : $unsigned($random(seed)) % 3;
      l = (i < 16) ? w + i / 8 : 1 + $unsigned($random(seed)) % 12;
      if (ty == 1) rg = rg % 2;
      if (ty == 1 && l == w) l = w + 2;
      wb(1'b1, `TSQ_OFS_CTRL, 32'h0);
      lvl_lo_i[c] <= (p == 1) || (p == 2 && i % 2 == 1);
      wb(1'b1, `TSQ_OFS_WIDTH, 32'(w));
      wb(1'b1, `TSQ_OFS_DELTA, 32'(dl));
      wb(1'b1, `TSQ_OFS_CTRL, cfg(ty, p, rg, c));
      n_trig = 0;
      pls(c, l);
      chk(n_trig, hit(ty, rg, l, w, dl));
    end
    // runt: low pulse fires, a pulse that also crosses the second threshold does not
    wb(1'b1, `TSQ_OFS_CTRL, 32'h0);
    lvl_lo_i <= 4'h0;
    wb(1'b1, `TSQ_OFS_CTRL, cfg(3, 0, 4, 0));
    n_trig = 0;
    pls(0, 4);
    lvl_lo_i[0] <= 1'b1;
    @(posedge clk_i);
    lvl_hi_i[0] <= 1'b1;
    repeat (2) @(posedge clk_i);
    lvl_hi_i[0] <= 1'b0;
    lvl_lo_i[0] <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(n_trig, 1);
    // external pin, plain and with noise reject; the lone pin without hysteresis stays low
    wb(1'b1, `TSQ_OFS_CTRL, 32'h11);
    n_trig = 0;
    ext_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    ext_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(n_trig, 1);
    wb(1'b1, `TSQ_OFS_CTRL, 32'h31);
    n_trig = 0;
    ext_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    ext_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(n_trig, 0);
    {ext_i, ext_hyst_i} <= 2'b11;
    repeat (6) @(posedge clk_i);
    {ext_i, ext_hyst_i} <= 2'b00;
    repeat (6) @(posedge clk_i);
    chk(n_trig, 1);
    // sequence: A ch0, B ch1 counted to 2 after delay 12, R ch2, timeout 40
    wb(1'b1, `TSQ_OFS_DELAY, 32'd12);
    wb(1'b1, `TSQ_OFS_COUNT, 32'd2);
    wb(1'b1, `TSQ_OFS_TMO, 32'd40);
    wb(1'b1, `TSQ_OFS_CTRL, cfg(0, 0, 0, 1) | 32'h0020_000E);
    n_trig = 0;
    pls(0, 1);
    pls(1, 1);
    repeat (12) @(posedge clk_i);
    pls(1, 1);
    chk(n_trig, 0);
    pls(1, 1);
    chk(n_trig, 1);
    pls(0, 1);
    repeat (14) @(posedge clk_i);
    pls(1, 1);
    pls(2, 1);
    pls(1, 1);
    chk(n_trig, 1);
    pls(0, 1);
    repeat (14) @(posedge clk_i);
    pls(1, 1);
    repeat (60) @(posedge clk_i);
    pls(1, 1);
    pls(1, 1);
    chk(n_trig, 1);
    pls(0, 1);
    repeat (14) @(posedge clk_i);
    pls(1, 1);
    pls(1, 1);
    chk(n_trig, 2);
    // interrupt: sticky status, masked, unmasked, cleared by writing ones
    wb(1'b0, `TSQ_OFS_IRQST, 32'h0);
    chk(rd & 32'h3, 32'h3);
    chk(irq_o, 1'b0);
    wb(1'b1, `TSQ_OFS_IRQMSK, 32'h3);
    chk(irq_o, 1'b1);
    wb(1'b1, `TSQ_OFS_IRQST, 32'h7);
    chk(irq_o, 1'b0);
    wb(1'b0, `TSQ_OFS_EVCNT, 32'h0);
    chk(rd, n_all);
    results;
  end
endmodule
`default_nettype wire
